//--- bench/cfg_word_source.sv
// model of the configuration word loader that feeds the clock ratio decoder
`timescale 1ns/1ps
module cfg_word_source
(
  // clock
  input wire logic core_clk,
  // command from the bench
  input wire logic go,
  input wire logic [255:0] word,
  // loader outputs
  output logic [255:0] cfg_word,
  output logic load_done
);
  // power-up state of the loader lines
  initial
  begin
    load_done = 1'b0;
    cfg_word = 256'h0;
  end
  // one load cycle per command; outside it the word toggles every cycle, so a late read sees junk
  always @(posedge core_clk)
  begin
    load_done <= go;
    cfg_word <= go ? word : ~cfg_word;
  end
endmodule

//--- bench/clock_ratio_config_decoder_tb.sv
// self-checking bench of the clock ratio decoder
`timescale 1ns/1ps
module clock_ratio_config_decoder_tb;
  import clk_cfg_pkg::*;
  localparam logic [4:0] CL_OK [8] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10};
  localparam logic [4:0] AS_OK [8] = '{5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10};
  localparam logic [3:0] CO_OK [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [255:0] word = 256'h0;
  logic [255:0] cfg_word;
  logic load_done;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  clk_sel_s clk_sel;
  cfg_err_s err_cause;
  logic mem_ref_platform, cfg_valid, cfg_error, mem_bus_clk_out, local_bus_clock_out;
  int failures = 0;
  int checks = 0;
  int seed = 60095;

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  // loader model and design
  cfg_word_source u_src (.core_clk(core_clk), .go(go), .word(word), .cfg_word(cfg_word), .load_done(load_done));
  clock_ratio_config_decoder u_dut (.core_clk(core_clk), .rst_n(rst_n), .reset_configuration_word(cfg_word),
    .rcw_load_done(load_done), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .clk_sel(clk_sel), .mem_ref_platform(mem_ref_platform), .cfg_valid(cfg_valid), .cfg_error(cfg_error),
    .err_cause(err_cause), .mem_bus_clk_out(mem_bus_clk_out), .local_bus_clock_out(local_bus_clock_out));

  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_sel(input clk_sel_s got, input clk_sel_s exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    cmp_rd(rd_data, exp);
  endtask
  task automatic do_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic load(input logic [255:0] w);
    @(posedge core_clk);
    word <= w;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ****************************************************************
  // stimulus and expectations
  // ****************************************************************
  function automatic int rnd(input int n);
    return {$random(seed)} % n;
  endfunction
  // mode 0 async, 1 sync, 2 reserved codes, 3 fixed bits broken
  function automatic logic [255:0] mk_word(input int mode);
    logic [255:0] w;
    for (int i = 0; i < 8; i++)
      w[32*i +: 32] = $random(seed);
    w[6:2] = 5'(5 + rnd(8));
    w[1:0] = 2'(rnd(2));
    for (int i = 0; i < 3; i++)
    begin
      w[16+8*i +: 5] = CL_OK[rnd(8)];
      w[21+8*i +: 2] = 2'(rnd(2));
    end
    for (int i = 0; i < 4; i++)
      w[64+4*i +: 4] = CO_OK[rnd(5)];
    // a core on cluster 3 keeps that PLL at a derated multiplier of 12 or less
    for (int i = 0; i < 4; i++)
      if (w[64+4*i +: 4] == 4'h8)
        w[32 +: 5] = CL_OK[rnd(5)];
    w[184] = (mode == 1) || (mode > 1 && rnd(2) == 1);
    w[232] = w[184];
    w[234] = 1'b0;
    w[9:8] = 2'(rnd(2));
    w[14:10] = w[184] ? 5'h01 : AS_OK[rnd(8)];
    if (mode == 2)
    begin
      w[6:2] = rnd(2) ? 5'h04 : 5'h0d;
      w[16 +: 5] = 5'h0d;
      w[24 +: 5] = 5'h07;
      w[32 +: 5] = 5'h0d;
      w[68 +: 4] = 4'h9;
      w[14:10] = w[184] ? 5'h05 : 5'h07;
    end
    if (mode == 3)
    begin
      if (rnd(2))
        w[232] = ~w[184];
      else
        w[234] = 1'b1;
      w[64 +: 4] = 4'h5; // corner: core 0 on cluster 2 halved
      w[6:2] = 5'h05;
      w[14:10] = w[184] ? 5'h01 : 5'h10; // corner: async data rate over twice the platform
    end
    return w;
  endfunction
  function automatic clk_sel_s exp_sel(input logic [255:0] w);
    clk_sel_s s;
    s.plat_mult = w[6:2];
    s.plat_range = w[1:0];
    for (int i = 0; i < 3; i++)
    begin
      s.cl_mult[i] = w[16+8*i +: 5];
      s.cl_range[i] = w[21+8*i +: 2];
    end
    for (int i = 0; i < 4; i++)
      s.core[i] = {w[66+4*i +: 2], w[64+4*i]};
    s.mem = {w[184], w[9:8], w[14:10]};
    return s;
  endfunction
  function automatic cfg_err_s exp_err(input logic [255:0] w);
    cfg_err_s e;
    logic [4:0] pc;
    logic [4:0] mc;
    pc = w[6:2];
    mc = w[14:10];
    e.plat = !(pc inside {[5'h05:5'h0c]});
    for (int i = 0; i < 3; i++)
      e.cl[i] = !(w[16+8*i +: 5] inside {[5'h08:5'h0c], 5'h0e, 5'h0f, 5'h10});
    for (int i = 0; i < 4; i++)
      e.core[i] = !(w[64+4*i +: 4] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8});
    e.mem = w[184] ? mc != 5'h01 : !(mc inside {5'h05, 5'h06, [5'h08:5'h0a], 5'h0c, 5'h0d, 5'h10});
    e.fixed = w[184] != w[232] || w[234];
    e.rate = !w[184] && !e.mem && !e.plat && mc > 2 * pc;
    return e;
  endfunction

  // watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end

  // main sequence
  initial
  begin
    logic [255:0] w;
    clk_sel_s s;
    cfg_err_s e;
    logic m;
    logic [15:0] hi;
    logic [31:0] d;
    int ne;
    do_reset();
    rd(4'h0, 32'h2);
    wr(4'h1, 32'hffff_ffff);
    wr(4'h3, 32'hffff_ffff);
    for (int a = 1; a < 16; a++)
      rd(4'(a), 32'h0);
    for (int it = 0; it < 16; it++)
    begin
      do_reset();
      cmp_val({15'h0, cfg_valid}, 16'h0);
      cmp_sel(clk_sel, '0);
      w = mk_word(it % 4);
      s = exp_sel(w);
      e = exp_err(w);
      for (int k = 0; k < 2; k++)
      begin
        load(k ? ~w : w);
        cmp_val({3'h0, cfg_valid, cfg_error, err_cause}, {3'h0, 1'b1, |e, e});
        if (it % 4 != 2)
          cmp_sel(clk_sel, s);
      end
      cmp_val({15'h0, mem_ref_platform}, {15'h0, w[184]});
      rd(4'h1, {20'h0, e, 1'b1});
      rd(4'h2, {4'h0, s.plat_mult, s.plat_range, s.cl_mult, s.cl_range});
      rd(4'h4, {23'h0, s.mem.sync, s.mem});
      if (it % 4 != 2)
        rd(4'h3, {20'h0, s.core});
      m = mem_bus_clk_out;
      @(negedge core_clk);
      cmp_val({15'h0, w[184] ? m ^ mem_bus_clk_out : m | mem_bus_clk_out}, {15'h0, w[184]});
    end
    do_reset();
    load(mk_word(1));
    for (int n = 0; n < 9; n++)
    begin
      if (n inside {0, 1, 2, 3, 5, 8})
      begin
        d = $random(seed);
        d[7:0] = 8'(n);
        ne = n < 2 ? 2 : n;
        wr(4'h0, d);
        rd(4'h0, {24'h0, d[7:0]});
        repeat (20) @(negedge core_clk);
        hi = 16'h0;
        repeat (120)
        begin
          @(negedge core_clk);
          hi = hi + {15'h0, local_bus_clock_out};
        end
        cmp_val(hi, 16'(120 / ne * (ne / 2)));
      end
    end
    do_reset();
    rd(4'h0, 32'h2);
    end_of_test();
  end
endmodule

//--- common/clk_cfg_defines.svh
// bit positions, register offsets and reset values of the clock ratio decoder
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH
`define RCW_W 256
`define PLAT_RANGE_LSB 0
`define PLAT_RAT_LSB 2
`define MEM_RANGE_LSB 8
`define MEM_RAT_LSB 10
`define CL_RAT_LSB 16
`define CL_STRIDE 8
`define CL_RANGE_OFS 5
`define CORE_SEL_LSB 64
`define CORE_SEL_STRIDE 4
`define MEM_SYNC_BIT 184
`define MEM_RATE_BIT 232
`define MEM_RSV0_BIT 234
`define PLAT_MULT_MIN 5'h05
`define PLAT_MULT_MAX 5'h0c
`define MEM_SYNC_CODE 5'h01
`define ADDR_W 4
`define LBCR_ADDR 4'h0
`define STATUS_ADDR 4'h1
`define PLL_ADDR 4'h2
`define CORE_ADDR 4'h3
`define MEM_ADDR 4'h4
`define LB_DIV_W 8
`define LBCR_DIV_RST 8'h02
`endif

//--- common/clk_cfg_pkg.sv
// types shared by the clock ratio decoder
package clk_cfg_pkg;
  typedef enum logic [1:0] {ST_WAIT = 2'b01, ST_HELD = 2'b10} cap_state_e;
  typedef struct packed {
    logic [1:0] cluster;
    logic div2;
  } core_sel_s;
  typedef struct packed {
    logic sync;
    logic [1:0] range;
    logic [4:0] mult;
  } mem_cfg_s;
  typedef struct packed {
    logic [4:0] plat_mult;
    logic [1:0] plat_range;
    logic [2:0][4:0] cl_mult;
    logic [2:0][1:0] cl_range;
    core_sel_s [3:0] core;
    mem_cfg_s mem;
  } clk_sel_s;
  typedef struct packed {
    logic rate;
    logic fixed;
    logic mem;
    logic [3:0] core;
    logic [2:0] cl;
    logic plat;
  } cfg_err_s;
endpackage

//--- hdl/clock_ratio_config_decoder.sv
// clock ratio decoder: captures and checks the clock fields of the reset configuration word
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"
// ****************************************************************
// ****************************************************************
module clock_ratio_config_decoder
#(
  parameter int LB_DIV_W = `LB_DIV_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration word loader
  input wire logic [`RCW_W-1:0] reset_configuration_word,
  input wire logic rcw_load_done,
  // register port
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // decoded selections to the PLLs and both memory controllers
  output clk_cfg_pkg::clk_sel_s clk_sel,
  output logic mem_ref_platform,
  // status
  output logic cfg_valid,
  output logic cfg_error,
  output clk_cfg_pkg::cfg_err_s err_cause,
  // derived clocks
  output logic mem_bus_clk_out,
  output logic local_bus_clock_out
);
  import clk_cfg_pkg::*;

  // ****************************************************************
  // decode functions
  // ****************************************************************

  // platform code is valid inside the 5..12 window
  function automatic logic plat_ok_f(input logic [4:0] code);
    plat_ok_f = (code >= `PLAT_MULT_MIN) && (code <= `PLAT_MULT_MAX);
  endfunction

  // cluster code equals its multiplier when valid
  function automatic logic cl_ok_f(input logic [4:0] code);
    case (code)
      5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10: cl_ok_f = 1'b1;
      default: cl_ok_f = 1'b0;
    endcase
  endfunction

  // core select: bits 3:2 pick the cluster, bit 0 the /2
  function automatic logic core_ok_f(input logic [3:0] code);
    case (code)
      4'h0, 4'h1, 4'h4, 4'h5, 4'h8: core_ok_f = 1'b1;
      default: core_ok_f = 1'b0;
    endcase
  endfunction

  // async memory code equals its data rate to reference ratio
  function automatic logic mem_async_ok_f(input logic [4:0] code);
    case (code)
      5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h10: mem_async_ok_f = 1'b1;
      default: mem_async_ok_f = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // field extraction and decode
  // ****************************************************************
  wire [4:0] plat_code;
  wire [1:0] plat_range;
  wire [4:0] mem_code;
  wire [1:0] mem_range;
  wire mem_sync;
  wire mem_rate;
  wire mem_rsv0;
  wire plat_ok;
  wire mem_ok;
  wire [2:0][4:0] cl_code;
  wire [2:0][1:0] cl_range;
  wire [2:0] cl_ok;
  wire [3:0][3:0] core_code;
  wire [3:0] core_ok;
  core_sel_s [3:0] core_dec;
  clk_sel_s sel_dec;
  cfg_err_s err_dec;

  // platform and memory fields
  assign plat_code = reset_configuration_word[`PLAT_RAT_LSB +: 5];
  assign plat_range = reset_configuration_word[`PLAT_RANGE_LSB +: 2];
  assign mem_code = reset_configuration_word[`MEM_RAT_LSB +: 5];
  assign mem_range = reset_configuration_word[`MEM_RANGE_LSB +: 2];
  assign mem_sync = reset_configuration_word[`MEM_SYNC_BIT];
  assign mem_rate = reset_configuration_word[`MEM_RATE_BIT];
  assign mem_rsv0 = reset_configuration_word[`MEM_RSV0_BIT];
  assign plat_ok = plat_ok_f(plat_code);
  assign mem_ok = mem_sync ? (mem_code == `MEM_SYNC_CODE) : mem_async_ok_f(mem_code);

  // the three cluster PLL fields
  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_cl
      assign cl_code[gc] = reset_configuration_word[`CL_RAT_LSB + gc * `CL_STRIDE +: 5];
      assign cl_range[gc] = reset_configuration_word[`CL_RAT_LSB + gc * `CL_STRIDE + `CL_RANGE_OFS +: 2];
      assign cl_ok[gc] = cl_ok_f(cl_code[gc]);
    end
  endgenerate

  // the four per-core selects
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++)
    begin : g_core
      assign core_code[gk] = reset_configuration_word[`CORE_SEL_LSB + gk * `CORE_SEL_STRIDE +: 4];
      assign core_ok[gk] = core_ok_f(core_code[gk]);
      assign core_dec[gk] = '{cluster: core_code[gk][3:2], div2: core_code[gk][0]};
    end
  endgenerate

  // one memory configuration feeds both controllers
  assign sel_dec = '{
    plat_mult: plat_code,
    plat_range: plat_range,
    cl_mult: cl_code,
    cl_range: cl_range,
    core: core_dec,
    mem: '{sync: mem_sync, range: mem_range, mult: mem_code}
  };

  // error causes; the fixed bits are checked although software owns them
  assign err_dec.plat = !plat_ok;
  assign err_dec.cl = ~cl_ok;
  assign err_dec.core = ~core_ok;
  assign err_dec.mem = !mem_ok;
  assign err_dec.fixed = (mem_sync != mem_rate) || mem_rsv0;
  assign err_dec.rate = !mem_sync && plat_ok && mem_ok && ({1'b0, mem_code} > {plat_code, 1'b0});

  // ****************************************************************
  // capture state machine
  // ****************************************************************
  cap_state_e state_r;
  cap_state_e state_nxt;
  wire capture;

  assign capture = (state_r == ST_WAIT) && rcw_load_done;

  // one capture per reset, then hold for good
  always_comb
  begin
    case (state_r)
      ST_WAIT: state_nxt = rcw_load_done ? ST_HELD : ST_WAIT;
      ST_HELD: state_nxt = ST_HELD;
      default: state_nxt = ST_WAIT;
    endcase
  end

  // ****************************************************************
  // held configuration and status
  // ****************************************************************
  clk_sel_s sel_nxt;
  cfg_err_s err_nxt;
  logic mem_bus_clk_nxt;

  // later load pulses cannot disturb running PLLs
  assign sel_nxt = capture ? sel_dec : clk_sel;
  assign err_nxt = capture ? err_dec : err_cause;
  // sync mode: memory bus clock toggles every platform cycle, half its rate
  assign mem_bus_clk_nxt = cfg_valid && clk_sel.mem.sync && !mem_bus_clk_out;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_WAIT;
      clk_sel <= '0;
      err_cause <= '0;
      cfg_valid <= 1'b0;
      cfg_error <= 1'b0;
      mem_ref_platform <= 1'b0;
      mem_bus_clk_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      clk_sel <= sel_nxt;
      err_cause <= err_nxt;
      cfg_valid <= cfg_valid || capture;
      cfg_error <= |err_nxt;
      mem_ref_platform <= sel_nxt.mem.sync;
      mem_bus_clk_out <= mem_bus_clk_nxt;
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  logic [LB_DIV_W-1:0] lb_div_r;
  logic [31:0] rd_mux;

  // read selection; unmapped offsets read zero
  always_comb
  begin
    case (addr)
      `LBCR_ADDR: rd_mux = {{(32 - LB_DIV_W){1'b0}}, lb_div_r};
      `STATUS_ADDR: rd_mux = {20'h0, err_cause, cfg_valid};
      `PLL_ADDR: rd_mux = {4'h0, clk_sel.plat_mult, clk_sel.plat_range, clk_sel.cl_mult, clk_sel.cl_range};
      `CORE_ADDR: rd_mux = {20'h0, clk_sel.core};
      `MEM_ADDR: rd_mux = {23'h0, mem_ref_platform, clk_sel.mem};
      default: rd_mux = 32'h0;
    endcase
  end

  // divider register write and one-cycle read data
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lb_div_r <= LB_DIV_W'(`LBCR_DIV_RST);
      rd_data <= 32'h0;
    end
    else
    begin
      if (wr_en && addr == `LBCR_ADDR)
      begin
        lb_div_r <= wr_data[LB_DIV_W-1:0];
      end
      rd_data <= rd_en ? rd_mux : 32'h0;
    end
  end

  // ****************************************************************
  // local bus clock
  // ****************************************************************
  // runs only once a configuration is held
  local_bus_clk_div #(.DIV_W(LB_DIV_W)) u_lb_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(cfg_valid),
    .ratio(lb_div_r),
    .clk_out(local_bus_clock_out)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_load;
    capture;
  endsequence

  sequence s_held2;
    cfg_valid ##1 cfg_valid;
  endsequence

  property p_capture;
    s_load |=> cfg_valid && clk_sel == $past(sel_dec);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_hold;
    s_held2 |-> $stable(clk_sel) && $stable(err_cause);
  endproperty
  a_hold: assert property (p_hold) else $error("held configuration changed");

  property p_plat_err;
    s_load ##0 !plat_ok |=> err_cause.plat && cfg_error;
  endproperty
  a_plat_err: assert property (p_plat_err) else $error("reserved platform code not flagged");

  property p_cl_err;
    s_load ##0 cl_code[2] == 5'h0d |=> err_cause.cl[2] && cfg_error;
  endproperty
  a_cl_err: assert property (p_cl_err) else $error("reserved cluster code not flagged");

  property p_core;
    s_load ##0 core_code[0] == 4'h5 |=> clk_sel.core[0].cluster == 2'h1 && clk_sel.core[0].div2 && !err_cause.core[0];
  endproperty
  a_core: assert property (p_core) else $error("core select decoded wrongly");

  property p_mem_async;
    s_load ##0 !mem_sync && mem_code == 5'h07 |=> err_cause.mem;
  endproperty
  a_mem_async: assert property (p_mem_async) else $error("reserved async memory code accepted");

  property p_mem_sync;
    s_load ##0 mem_sync && mem_code != `MEM_SYNC_CODE |=> err_cause.mem && cfg_error;
  endproperty
  a_mem_sync: assert property (p_mem_sync) else $error("invalid sync memory code accepted");

  property p_mem_ref;
    cfg_valid |-> mem_ref_platform == clk_sel.mem.sync;
  endproperty
  a_mem_ref: assert property (p_mem_ref) else $error("memory reference select wrong");

  property p_mem_bus;
    s_held2 ##0 clk_sel.mem.sync |-> mem_bus_clk_out != $past(mem_bus_clk_out);
  endproperty
  a_mem_bus: assert property (p_mem_bus) else $error("sync memory bus clock not half rate");

  property p_rate;
    s_load ##0 !mem_sync && plat_code == 5'h05 && mem_code == 5'h10 |=> err_cause.rate;
  endproperty
  a_rate: assert property (p_rate) else $error("data rate over twice platform not flagged");

  property p_read;
    rd_en && addr == `STATUS_ADDR |=> rd_data == $past({20'h0, err_cause, cfg_valid}) ##1 rd_data == 32'h0 || $past(rd_en);
  endproperty
  a_read: assert property (p_read) else $error("status read data wrong");
endmodule

//--- hdl/local_bus_clk_div.sv
// divider that makes the local bus output clock from the platform clock
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"
module local_bus_clk_div
#(
  parameter int DIV_W = `LB_DIV_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] ratio,
  // divided clock
  output logic clk_out
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic [DIV_W-1:0] ratio_eff;
  logic [DIV_W-1:0] half;
  logic clk_out_nxt;

  // ratios below two cannot make a clock, so they act as two
  assign ratio_eff = (ratio < DIV_W'(2)) ? DIV_W'(2) : ratio;
  assign half = ratio_eff >> 1;
  assign cnt_nxt = (!run || cnt_r >= ratio_eff - DIV_W'(1)) ? '0 : cnt_r + DIV_W'(1);
  assign clk_out_nxt = run && (cnt_nxt < half);

  // counter and output flop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      clk_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      clk_out <= clk_out_nxt;
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_lb_wrap;
    run && cnt_r == ratio_eff - DIV_W'(1) |=> cnt_r == '0;
  endproperty
  a_lb_wrap: assert property (p_lb_wrap) else $error("divider count did not wrap");

  property p_lb_idle;
    !run |=> !clk_out && cnt_r == '0;
  endproperty
  a_lb_idle: assert property (p_lb_idle) else $error("divider ran while stopped");
endmodule
